// [verilog/gdp_pkg.sv]
// shared constants for the gpio direction and pull-up block
package gdp_pkg;
    // geometry: groups a, b, c, e, f, g, h in index order 0..6
    localparam int GROUPS = 7;
    localparam int PINS = 8;
    localparam int SYNC_STAGES = 3;

    // reset values of the stored fields
    localparam logic [7:0] DIR_RESET = 8'hff;
    localparam logic [7:0] PU_RESET = 8'h00;
    localparam logic [7:0] DATA_RESET = 8'hff;
    localparam logic [7:0] READ_IDLE = 8'h00;

    // implemented pins per group: a and g carry four, the rest eight
    localparam logic [GROUPS-1:0][7:0] IMPL_MASK = {
        8'hff, 8'h0f, 8'hff, 8'hff, 8'hff, 8'hff, 8'h0f
    };

    // special-function addresses of the direction registers
    localparam logic [GROUPS-1:0][7:0] DIR_ADDR = {
        8'hf7, 8'hf2, 8'hef, 8'hee, 8'hec, 8'heb, 8'hea
    };

    // special-function addresses of the port data registers
    localparam logic [GROUPS-1:0][7:0] DATA_ADDR = {
        8'hd8, 8'hc8, 8'hc0, 8'hb0, 8'h90, 8'h80, 8'hf8
    };

    // secondary bus addresses of the pull-up enable registers
    localparam logic [GROUPS-1:0][7:0] PU_ADDR = {
        8'h1e, 8'h1d, 8'h1c, 8'h1b, 8'h19, 8'h18, 8'h17
    };
endpackage

// [verilog/gdp_pad_if.sv]
// per-group pad control signals between the core and the pad logic
interface gdp_pad_if #(
    parameter int WIDTH = 8
);
    logic [WIDTH-1:0] mask;
    logic [WIDTH-1:0] dir;
    logic [WIDTH-1:0] pu;
    logic [WIDTH-1:0] dat;
    logic [WIDTH-1:0] lvl;
    logic [WIDTH-1:0] rbk;
    logic [WIDTH-1:0] pad_out;
    logic [WIDTH-1:0] pad_oe;
    logic [WIDTH-1:0] pad_pu;

    // core side drives settings, reads back pad results
    modport core (
        output mask, dir, pu, dat, lvl,
        input rbk, pad_out, pad_oe, pad_pu
    );

    // pad side turns settings into pad controls and readback
    modport ctrl (
        input mask, dir, pu, dat, lvl,
        output rbk, pad_out, pad_oe, pad_pu
    );
endinterface

// [verilog/gdp_pin_sync.sv]
// three-stage pin synchroniser with agreement filter
module gdp_pin_sync #(
    parameter int WIDTH = 56
) (
    // clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // raw pins and filtered level
    input wire logic [WIDTH-1:0] pin_raw,
    output logic [WIDTH-1:0] level
);
    typedef struct packed {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
        logic [WIDTH-1:0] s3;
        logic [WIDTH-1:0] lvl;
    } gdp_sync_s;

    gdp_sync_s r;
    gdp_sync_s next_r;
    logic [WIDTH-1:0] differ;

    // shift chain; level follows only when stages two and three agree
    always_comb begin
        next_r = r;
        differ = r.s2 ^ r.s3;
        next_r.s1 = pin_raw;
        next_r.s2 = r.s1;
        next_r.s3 = r.s2;
        next_r.lvl = (r.s2 & ~differ) | (r.lvl & differ);
    end

    // state register
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign level = r.lvl;
endmodule // gdp_pin_sync

// [verilog/gdp_pad_ctrl.sv]
// pad driver, pull-up and readback logic for one port group
module gdp_pad_ctrl (
    // settings in, pad controls out
    gdp_pad_if.ctrl bus
);
    // direction 0 drives, 1 releases the pad
    always_comb begin
        bus.pad_oe = ~bus.dir & bus.mask;
        bus.pad_out = bus.dat & ~bus.dir & bus.mask;
        bus.pad_pu = bus.pu & bus.mask;
        // input pins show the pin, output pins the latch
        bus.rbk = ((bus.lvl & bus.dir) | (bus.dat & ~bus.dir)) & bus.mask;
    end
endmodule // gdp_pad_ctrl

// [verilog/gdp_top.sv]
// gpio direction and pull-up control for seven port groups
// How it works
// - direction bit 0 makes a pin output, 1 makes it input.
// - after reset every implemented direction bit reads 1, all pins inputs.
// - group a direction uses bits 3..0 only; bits 7..4 unimplemented.
// - group g direction uses bits 3..0; b, c, e, f, h use eight.
// - direction registers sit at ea, eb, ec, ee, ef, f2, f7 special addresses.
// - pull-up bit 1 connects the internal pull-up, 0 leaves it off.
// - after reset every implemented pull-up bit reads 0.
// - pull-up registers of groups a and g use bits 3..0 only.
// - pull-up registers sit on the secondary bus at 17 through 1e.
// - data read gives pin level for inputs, stored value for outputs.
module gdp_top (
    // clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // special-function register port
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_wdata,
    output logic [7:0] sfr_rdata,
    // secondary register bus
    input wire logic [7:0] sec_addr,
    input wire logic sec_wr,
    input wire logic sec_rd,
    input wire logic [7:0] sec_wdata,
    output logic [7:0] sec_rdata,
    // pads, group index 0..6 is a, b, c, e, f, g, h
    input wire logic [gdp_pkg::GROUPS-1:0][gdp_pkg::PINS-1:0] pin_in,
    output logic [gdp_pkg::GROUPS-1:0][gdp_pkg::PINS-1:0] pin_out,
    output logic [gdp_pkg::GROUPS-1:0][gdp_pkg::PINS-1:0] pin_oe,
    output logic [gdp_pkg::GROUPS-1:0][gdp_pkg::PINS-1:0] pin_pullup
);
    typedef logic [gdp_pkg::GROUPS-1:0][gdp_pkg::PINS-1:0] gdp_bank_t;

    typedef struct packed {
        gdp_bank_t dir;
        gdp_bank_t pu;
        gdp_bank_t dat;
        gdp_bank_t pad_out;
        gdp_bank_t pad_oe;
        gdp_bank_t pad_pu;
        logic [7:0] sfr_rdata;
        logic [7:0] sec_rdata;
    } gdp_top_s;

    // all pins inputs, no pull-ups, latches high, pads released
    localparam gdp_top_s RESET_STATE = '{
        dir: {gdp_pkg::GROUPS{gdp_pkg::DIR_RESET}},
        pu: {gdp_pkg::GROUPS{gdp_pkg::PU_RESET}},
        dat: {gdp_pkg::GROUPS{gdp_pkg::DATA_RESET}},
        pad_out: '0,
        pad_oe: '0,
        pad_pu: '0,
        sfr_rdata: gdp_pkg::READ_IDLE,
        sec_rdata: gdp_pkg::READ_IDLE
    };

    gdp_top_s r;
    gdp_top_s next_r;
    gdp_bank_t level;
    gdp_bank_t rbk;
    gdp_bank_t pad_out_nx;
    gdp_bank_t pad_oe_nx;
    gdp_bank_t pad_pu_nx;

    // pin levels enter the clock domain here
    gdp_pin_sync #(
        .WIDTH(gdp_pkg::GROUPS * gdp_pkg::PINS)
    ) u_sync (
        .clk(clk),
        .arst_n(arst_n),
        .pin_raw(pin_in),
        .level(level)
    );

    gdp_pad_if #(.WIDTH(gdp_pkg::PINS)) pad_bus [gdp_pkg::GROUPS] ();

    // one pad controller per group, fed with the next register values
    // so the pads switch on the same edge as the register
    for (genvar g = 0; g < gdp_pkg::GROUPS; g++) begin : g_group
        assign pad_bus[g].mask = gdp_pkg::IMPL_MASK[g];
        assign pad_bus[g].dir = next_r.dir[g];
        assign pad_bus[g].pu = next_r.pu[g];
        assign pad_bus[g].dat = next_r.dat[g];
        assign pad_bus[g].lvl = level[g];
        assign rbk[g] = pad_bus[g].rbk;
        assign pad_out_nx[g] = pad_bus[g].pad_out;
        assign pad_oe_nx[g] = pad_bus[g].pad_oe;
        assign pad_pu_nx[g] = pad_bus[g].pad_pu;

        gdp_pad_ctrl u_pad (
            .bus(pad_bus[g])
        );
    end

    // register writes on both buses
    always_comb begin
        next_r = r;
        for (int g = 0; g < gdp_pkg::GROUPS; g++) begin
            // direction writes keep only the implemented pins
            if (sfr_wr && sfr_addr == gdp_pkg::DIR_ADDR[g]) begin
                next_r.dir[g] = sfr_wdata | ~gdp_pkg::IMPL_MASK[g];
            end
            if (sfr_wr && sfr_addr == gdp_pkg::DATA_ADDR[g]) begin
                next_r.dat[g] = sfr_wdata | ~gdp_pkg::IMPL_MASK[g];
            end
            // pull-ups live on the secondary bus only
            if (sec_wr && sec_addr == gdp_pkg::PU_ADDR[g]) begin
                next_r.pu[g] = sec_wdata & gdp_pkg::IMPL_MASK[g];
            end
        end
    end

    // special-function reads: direction and data, unmapped read as zero
    logic [7:0] sfr_sel;
    always_comb begin
        sfr_sel = gdp_pkg::READ_IDLE;
        for (int g = 0; g < gdp_pkg::GROUPS; g++) begin
            if (sfr_addr == gdp_pkg::DIR_ADDR[g]) begin
                sfr_sel = r.dir[g] & gdp_pkg::IMPL_MASK[g];
            end
            if (sfr_addr == gdp_pkg::DATA_ADDR[g]) begin
                sfr_sel = rbk[g];
            end
        end
    end

    // secondary reads: pull-up enables, unmapped read as zero
    logic [7:0] sec_sel;
    always_comb begin
        sec_sel = gdp_pkg::READ_IDLE;
        for (int g = 0; g < gdp_pkg::GROUPS; g++) begin
            if (sec_addr == gdp_pkg::PU_ADDR[g]) begin
                sec_sel = r.pu[g] & gdp_pkg::IMPL_MASK[g];
            end
        end
    end

    // read data is captured on the strobe and held until the next one;
    // pad copies join here so the pad path never feeds back into next_r
    gdp_top_s next_q;
    always_comb begin
        next_q = next_r;
        next_q.pad_out = pad_out_nx;
        next_q.pad_oe = pad_oe_nx;
        next_q.pad_pu = pad_pu_nx;
        if (sfr_rd) begin
            next_q.sfr_rdata = sfr_sel;
        end
        if (sec_rd) begin
            next_q.sec_rdata = sec_sel;
        end
    end

    // state register; reset leaves every pin an input with no pull-up
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            r <= RESET_STATE;
        end else begin
            r <= next_q;
        end
    end

    // outputs straight from flip-flops
    assign sfr_rdata = r.sfr_rdata;
    assign sec_rdata = r.sec_rdata;
    assign pin_out = r.pad_out;
    assign pin_oe = r.pad_oe;
    assign pin_pullup = r.pad_pu;
endmodule // gdp_top

// [tb/gdp_top_assertions.sv]
// port properties of the direction and pull-up block
module gdp_top_assertions (
    // clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // special-function port
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic [7:0] sfr_wdata,
    // secondary port
    input wire logic [7:0] sec_addr,
    input wire logic sec_wr,
    input wire logic sec_rd,
    input wire logic [7:0] sec_wdata,
    input wire logic [7:0] sec_rdata,
    // pads
    input wire logic [6:0][7:0] pin_out,
    input wire logic [6:0][7:0] pin_oe,
    input wire logic [6:0][7:0] pin_pullup
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    // register writes reach the pads on the storing edge
    a_dir_a_oe: assert property (
        sfr_wr && sfr_addr == 8'hea |=> pin_oe[0] == {4'h0, ~$past(sfr_wdata[3:0])})
        else $error("group a enables wrong");
    a_dir_h_oe: assert property (
        sfr_wr && sfr_addr == 8'hf7 |=> pin_oe[6] == ~$past(sfr_wdata))
        else $error("group h enables wrong");
    a_pu_a_write: assert property (
        sec_wr && sec_addr == 8'h17 |=> pin_pullup[0] == {4'h0, $past(sec_wdata[3:0])})
        else $error("group a pull-ups wrong");
    a_pu_g_read: assert property (
        sec_rd && sec_addr == 8'h1d |=> sec_rdata == {4'h0, pin_pullup[5][3:0]})
        else $error("group g pull-up readback wrong");
    a_hole_reads_zero: assert property (
        sec_rd && sec_addr == 8'h1a |=> sec_rdata == 8'h00)
        else $error("unmapped read not zero");
    a_drive_gated: assert property (
        (pin_out & ~pin_oe) == '0)
        else $error("drive value without enable");
    a_unimpl_quiet: assert property (
        {pin_oe[0][7:4], pin_oe[5][7:4], pin_pullup[0][7:4], pin_pullup[5][7:4]} == '0)
        else $error("unimplemented pin active");
    a_reset_quiet: assert property (
        $rose(arst_n) |-> pin_oe == '0 && pin_pullup == '0)
        else $error("pads active after reset");
    // main scenarios
    c_dir_write: cover property (sfr_wr && sfr_addr == 8'hea);
    c_pu_write: cover property (sec_wr && sec_addr == 8'h17);
    c_drive_b: cover property (pin_oe[1] != 8'h00);
endmodule // gdp_top_assertions

// [tb/gdp_pins_model.sv]
// board side of the pads: block drive, board source, pull-up or float
module gdp_pins_model (
    // clock for the float pattern
    input wire logic clk,
    // pad controls and board sources
    input wire logic [6:0][7:0] pin_out,
    input wire logic [6:0][7:0] pin_oe,
    input wire logic [6:0][7:0] pin_pullup,
    input wire logic [6:0][7:0] ext_val,
    input wire logic [6:0][7:0] ext_en,
    // resolved levels
    output logic [6:0][7:0] level
);
    timeunit 1ns;
    timeprecision 1ns;
    logic flt = 1'b0;
    // undriven pads without pull-up change every cycle
    always @(posedge clk) flt <= ~flt;
    // block drive first, then board, then pull-up
    assign level = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val)
        | (~pin_oe & ~ext_en & (pin_pullup | {56{flt}}));
endmodule // gdp_pins_model

// [tb/tb_gdp_top.sv]
// self-checking bench for the direction and pull-up block
module tb_gdp_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, sec_addr = 8'h00, sec_wdata = 8'h00;
    logic sfr_wr = 1'b0, sfr_rd = 1'b0, sec_wr = 1'b0, sec_rd = 1'b0;
    logic [7:0] sfr_rdata, sec_rdata, q, m, d, p, v;
    logic [6:0][7:0] pin_in, pin_out, pin_oe, pin_pullup, ext_val = '0, ext_en = '1;
    localparam logic [6:0][7:0] dir_at = {8'hf7, 8'hf2, 8'hef, 8'hee, 8'hec, 8'heb, 8'hea};
    localparam logic [6:0][7:0] pu_at = {8'h1e, 8'h1d, 8'h1c, 8'h1b, 8'h19, 8'h18, 8'h17};
    int mismatches = 0, tests_run = 0, cycles = 0, g;
    always #50 clk = ~clk;
    gdp_top u_gdp_top (.clk(clk), .arst_n(arst_n), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
        .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .sec_addr(sec_addr),
        .sec_wr(sec_wr), .sec_rd(sec_rd), .sec_wdata(sec_wdata), .sec_rdata(sec_rdata),
        .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup(pin_pullup));
    gdp_pins_model u_gdp_pins_model (.clk(clk), .pin_out(pin_out), .pin_oe(pin_oe),
        .pin_pullup(pin_pullup), .ext_val(ext_val), .ext_en(ext_en), .level(pin_in));
    // implemented pins of a group
    function automatic logic [7:0] msk(int gg);
        return (gg == 0 || gg == 5) ? 8'h0f : 8'hff;
    endfunction
    // one access on either port, strobe held for one edge
    task automatic acc(input bit sec, input bit w, input logic [7:0] a, input logic [7:0] wd);
        @(negedge clk);
        {sfr_addr, sec_addr, sfr_wdata, sec_wdata} = {a, a, wd, wd};
        {sec_wr, sec_rd, sfr_wr, sfr_rd} = {sec & w, sec & !w, !sec & w, !sec & !w};
        @(posedge clk);
        #1 q = sec ? sec_rdata : sfr_rdata;
        @(negedge clk);
        {sec_wr, sec_rd, sfr_wr, sfr_rd} = 4'h0;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // hang guard
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            mismatches++;
            complete_run();
        end
    end
    initial begin
        void'($urandom(84));
        repeat (20) @(posedge clk);
        @(negedge clk) arst_n = 1'b1;
        // reset values of every group
        for (g = 0; g < 7; g++) begin
            acc(0, 0, dir_at[g], 8'h00);
            chk(q, msk(g));
            acc(1, 0, pu_at[g], 8'h00);
            chk(q, 8'h00);
            chk(pin_oe[g] | pin_pullup[g], 8'h00);
        end
        // random settings, pad and readback checks
        repeat (40) begin
            g = $urandom_range(6);
            m = msk(g);
            {d, p, v} = 24'($urandom);
            ext_val[g] = 8'($urandom);
            acc(0, 1, dir_at[g], d);
            acc(1, 1, pu_at[g], p);
            acc(0, 1, gdp_pkg::DATA_ADDR[g], v);
            chk(pin_oe[g], ~d & m);
            chk(pin_out[g], v & ~d & m);
            chk(pin_pullup[g], p & m);
            acc(0, 0, dir_at[g], 8'h00);
            chk(q, d & m);
            acc(1, 0, pu_at[g], 8'h00);
            chk(q, p & m);
            repeat (4) @(posedge clk);
            acc(0, 0, gdp_pkg::DATA_ADDR[g], 8'h00);
            chk(q, ((v & ~d) | (ext_val[g] & d)) & m);
        end
        // pull-up alone holds an undriven input high
        ext_en[1] = 8'h00;
        acc(0, 1, 8'heb, 8'hff);
        acc(1, 1, 8'h18, 8'hff);
        repeat (4) @(posedge clk);
        acc(0, 0, 8'h80, 8'h00);
        chk(q, 8'hff);
        // unmapped places read zero and ignore writes
        acc(1, 1, 8'h1a, 8'h5a);
        acc(1, 0, 8'h1a, 8'h00);
        chk(q, 8'h00);
        // special-function read data stands across other-port accesses
        chk(sfr_rdata, 8'hff);
        // mid-run reset puts every pad back to input without pull-up
        @(negedge clk) arst_n = 1'b0;
        @(negedge clk) arst_n = 1'b1;
        chk(sfr_rdata, 8'h00);
        for (g = 0; g < 7; g++) begin
            chk(pin_oe[g] | pin_pullup[g], 8'h00);
        end
        acc(0, 0, 8'hf7, 8'h00);
        chk(q, 8'hff);
        acc(1, 0, 8'h1e, 8'h00);
        chk(q, 8'h00);
        acc(0, 1, 8'he9, 8'ha5);
        acc(0, 0, 8'he9, 8'h00);
        chk(q, 8'h00);
        complete_run();
    end
endmodule // tb_gdp_top
bind gdp_top gdp_top_assertions u_gdp_top_assertions (.clk(clk), .arst_n(arst_n),
    .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata), .sec_addr(sec_addr),
    .sec_wr(sec_wr), .sec_rd(sec_rd), .sec_wdata(sec_wdata), .sec_rdata(sec_rdata),
    .pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup(pin_pullup));
